// ### rtl/tls_pkg.sv
package tls_pkg;

    // =========================================================
    // Widths
    localparam int PCT_W  = 9;
    localparam int SEL_W  = 3;
    localparam int MODE_W = 4;
    localparam int TRQ_W  = 16;

    // =========================================================
    // Limits and defaults, percent of rated torque
    localparam logic [PCT_W-1:0] PCT_MAX          = 9'h12c;
    localparam logic [PCT_W-1:0] FWD_INT_DEFAULT  = 9'h12c;
    localparam logic [PCT_W-1:0] REV_INT_DEFAULT  = 9'h12c;
    localparam logic [PCT_W-1:0] FWD_EXT_DEFAULT  = 9'h064;
    localparam logic [PCT_W-1:0] REV_EXT_DEFAULT  = 9'h064;

    // =========================================================
    // Output function selectors
    localparam logic [SEL_W-1:0] SEL_MAX          = 3'h4;
    localparam logic [SEL_W-1:0] PAIR_A_DEFAULT   = 3'h0;
    localparam logic [SEL_W-1:0] PAIR_B_DEFAULT   = 3'h1;
    localparam logic [SEL_W-1:0] PAIR_C_DEFAULT   = 3'h2;
    localparam logic [MODE_W-1:0] MODE_DEFAULT    = 4'h0;

    // =========================================================
    // Register offsets
    localparam logic [3:0] ADDR_FWD_INT   = 4'h0;
    localparam logic [3:0] ADDR_REV_INT   = 4'h1;
    localparam logic [3:0] ADDR_FWD_EXT   = 4'h2;
    localparam logic [3:0] ADDR_REV_EXT   = 4'h3;
    localparam logic [3:0] ADDR_MODE      = 4'h4;
    localparam logic [3:0] ADDR_PAIR_A    = 4'h5;
    localparam logic [3:0] ADDR_PAIR_B    = 4'h6;
    localparam logic [3:0] ADDR_PAIR_C    = 4'h7;
    localparam logic [3:0] ADDR_MOTOR_MAX = 4'h8;
    localparam logic [3:0] ADDR_STATUS    = 4'h9;
    localparam logic [3:0] ADDR_IRQ_STAT  = 4'ha;
    localparam logic [3:0] ADDR_IRQ_MASK  = 4'hb;

    typedef enum logic [1:0]
    {
        SPD_SWITCH = 2'b00,
        SPD_ONE    = 2'b01,
        SPD_TWO    = 2'b11,
        SPD_THREE  = 2'b10
    } tls_speed_t;

    typedef struct packed
    {
        logic position_complete_n;
        logic rotation_detect_n;
        logic servo_ready_n;
        logic brake_interlock;
    } tls_status_t;

endpackage

// ### rtl/tls_torque_limit.sv
// What this block does
// - Forward internal limit 0..300, default 300
// - Reverse internal limit 0..300, default 300
// - Forward external limit 0..300, default 100
// - Reverse external limit 0..300, default 100
// - Clamp limit to motor maximum torque
// - Forward select low picks external limit
// - Reverse select low picks external limit
// - Detect low while reference exceeds limit
// - Detect works for internal and external limits
// - Three output selectors 0..4, defaults 0,1,2
// - Selector codes map status functions
// - Modes 3..6 ignore limit selects
// - Internal speed modes decode select pair
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
module tls_torque_limit
(
    // Clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_arst_n,
    // Register port
    input  wire logic [3:0]                i_addr,
    input  wire logic [15:0]               i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output logic      [15:0]               o_rdata,
    // Contact inputs, active low
    input  wire logic                      i_fwd_limit_select_n,
    input  wire logic                      i_rev_limit_select_n,
    input  wire logic                      i_mode_switch_in_n,
    // Torque path, signed, units of percent
    input  wire logic signed [15:0]        i_torque_ref,
    output logic signed [15:0]             o_torque_cmd,
    // Status sources from the drive
    input  wire tls_pkg::tls_status_t      i_status,
    // Outputs
    output logic                           o_torque_limit_detect_n,
    output logic      [2:0]                o_pair_out,
    output logic      [1:0]                o_speed_select,
    output logic                           o_speed_reverse,
    output logic                           o_speed_mode_switch,
    output logic                           o_irq
);

    // =========================================================
    // Configuration registers
    logic [8:0]  fwd_internal_torque_limit_reg;
    logic [8:0]  rev_internal_torque_limit_reg;
    logic [8:0]  fwd_external_torque_limit_reg;
    logic [8:0]  rev_external_torque_limit_reg;
    logic [3:0]  control_mode_select_reg;
    logic [2:0]  pair_sel_reg [3];
    logic [8:0]  motor_max_reg;
    logic [1:0]  irq_stat_reg;
    logic [1:0]  irq_mask_reg;

    function automatic logic [8:0] pct_clip(input logic [15:0] v);
        pct_clip = (v > 16'(tls_pkg::PCT_MAX)) ? tls_pkg::PCT_MAX : v[8:0];
    endfunction

    function automatic logic [2:0] sel_clip(input logic [15:0] v);
        sel_clip = (v > 16'(tls_pkg::SEL_MAX)) ? tls_pkg::SEL_MAX : v[2:0];
    endfunction

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            fwd_internal_torque_limit_reg <= tls_pkg::FWD_INT_DEFAULT;
            rev_internal_torque_limit_reg <= tls_pkg::REV_INT_DEFAULT;
            fwd_external_torque_limit_reg <= tls_pkg::FWD_EXT_DEFAULT;
            rev_external_torque_limit_reg <= tls_pkg::REV_EXT_DEFAULT;
            control_mode_select_reg       <= tls_pkg::MODE_DEFAULT;
            motor_max_reg                 <= tls_pkg::PCT_MAX;
            irq_mask_reg                  <= 2'h0;
        end
        else if (i_wr)
        begin
            // Out of range limit writes saturate; mode and mask writes keep only the low bits
            unique case (i_addr)
                tls_pkg::ADDR_FWD_INT:   fwd_internal_torque_limit_reg <= pct_clip(i_wdata);
                tls_pkg::ADDR_REV_INT:   rev_internal_torque_limit_reg <= pct_clip(i_wdata);
                tls_pkg::ADDR_FWD_EXT:   fwd_external_torque_limit_reg <= pct_clip(i_wdata);
                tls_pkg::ADDR_REV_EXT:   rev_external_torque_limit_reg <= pct_clip(i_wdata);
                tls_pkg::ADDR_MODE:      control_mode_select_reg       <= i_wdata[3:0];
                tls_pkg::ADDR_MOTOR_MAX: motor_max_reg                 <= pct_clip(i_wdata);
                tls_pkg::ADDR_IRQ_MASK:  irq_mask_reg                  <= i_wdata[1:0];
                default: ;
            endcase
        end
    end

    // =========================================================
    // Output function selectors
    localparam logic [2:0] SEL_DEF [3] = '{tls_pkg::PAIR_A_DEFAULT,
                                           tls_pkg::PAIR_B_DEFAULT,
                                           tls_pkg::PAIR_C_DEFAULT};
    localparam logic [3:0] SEL_ADR [3] = '{tls_pkg::ADDR_PAIR_A,
                                           tls_pkg::ADDR_PAIR_B,
                                           tls_pkg::ADDR_PAIR_C};

    // =========================================================
    // Input synchronisers
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sync1_reg <= 3'h7;
            sync2_reg <= 3'h7;
        end
        else
        begin
            sync1_reg <= {i_mode_switch_in_n, i_rev_limit_select_n, i_fwd_limit_select_n};
            sync2_reg <= sync1_reg;
        end
    end

    logic fwd_sel_n;
    logic rev_sel_n;
    logic mode_sw_n;
    assign fwd_sel_n = sync2_reg[0];
    assign rev_sel_n = sync2_reg[1];
    assign mode_sw_n = sync2_reg[2];

    // =========================================================
    // Limit selection and clamp
    logic internal_speed;
    logic [8:0] fwd_limit;
    logic [8:0] rev_limit;
    logic [8:0] fwd_eff;
    logic [8:0] rev_eff;

    assign internal_speed = (control_mode_select_reg >= 4'h3) &&
                            (control_mode_select_reg <= 4'h6);

    assign fwd_limit = (!internal_speed && !fwd_sel_n) ? fwd_external_torque_limit_reg
                                                       : fwd_internal_torque_limit_reg;
    assign rev_limit = (!internal_speed && !rev_sel_n) ? rev_external_torque_limit_reg
                                                       : rev_internal_torque_limit_reg;
    assign fwd_eff = (fwd_limit > motor_max_reg) ? motor_max_reg : fwd_limit;
    assign rev_eff = (rev_limit > motor_max_reg) ? motor_max_reg : rev_limit;

    logic signed [15:0] fwd_lim_s;
    logic signed [15:0] rev_lim_s;
    logic               over_fwd;
    logic               over_rev;
    assign fwd_lim_s = $signed({7'h00, fwd_eff});
    assign rev_lim_s = -$signed({7'h00, rev_eff});
    assign over_fwd  = i_torque_ref > fwd_lim_s;
    assign over_rev  = i_torque_ref < rev_lim_s;

    // =========================================================
    // Torque command and detect, registered once per cycle
    logic detect_n_reg;
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_torque_cmd <= 16'sh0000;
            detect_n_reg <= 1'b1;
        end
        else
        begin
            o_torque_cmd <= over_fwd ? fwd_lim_s : (over_rev ? rev_lim_s : i_torque_ref);
            detect_n_reg <= !(over_fwd || over_rev);
        end
    end
    assign o_torque_limit_detect_n = detect_n_reg;

    // =========================================================
    // Internal speed selection
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_speed_select      <= 2'h0;
            o_speed_reverse     <= 1'b0;
            o_speed_mode_switch <= 1'b0;
        end
        else
        begin
            o_speed_select      <= internal_speed ? {!fwd_sel_n, !rev_sel_n} : 2'h0;
            o_speed_reverse     <= internal_speed && !mode_sw_n;
            o_speed_mode_switch <= internal_speed && fwd_sel_n && rev_sel_n;
        end
    end

    // =========================================================
    // Output pin pair routing
    function automatic logic route(input logic [2:0] sel, input tls_pkg::tls_status_t s,
                                   input logic det_n);
        unique case (sel)
            3'h0:    route = s.position_complete_n;
            3'h1:    route = s.rotation_detect_n;
            3'h2:    route = s.servo_ready_n;
            3'h3:    route = det_n;
            default: route = s.brake_interlock;
        endcase
    endfunction

    for (genvar g = 0; g < 3; g++)
    begin : g_pair
        always_ff @(posedge i_clk or negedge i_arst_n)
        begin
            if (!i_arst_n)
                pair_sel_reg[g] <= SEL_DEF[g];
            else if (i_wr && i_addr == SEL_ADR[g])
                pair_sel_reg[g] <= sel_clip(i_wdata);
        end
        always_ff @(posedge i_clk or negedge i_arst_n)
        begin
            if (!i_arst_n)
                o_pair_out[g] <= 1'b1;
            else
                o_pair_out[g] <= route(pair_sel_reg[g], i_status, detect_n_reg);
        end
    end

    // =========================================================
    // Interrupts: bit0 detect entered, bit1 detect left; set beats clear
    logic det_prev_reg;
    logic [1:0] irq_set;
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            det_prev_reg <= 1'b1;
        else
            det_prev_reg <= detect_n_reg;
    end
    assign irq_set = {detect_n_reg & ~det_prev_reg, ~detect_n_reg & det_prev_reg};

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            irq_stat_reg <= 2'h0;
        else if (i_wr && i_addr == tls_pkg::ADDR_IRQ_STAT)
            irq_stat_reg <= (irq_stat_reg & ~i_wdata[1:0]) | irq_set;
        else
            irq_stat_reg <= irq_stat_reg | irq_set;
    end
    assign o_irq = |(irq_stat_reg & irq_mask_reg);

    // =========================================================
    // Read port
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_rdata <= 16'h0000;
        else if (i_rd)
        begin
            unique case (i_addr)
                tls_pkg::ADDR_FWD_INT:   o_rdata <= {7'h00, fwd_internal_torque_limit_reg};
                tls_pkg::ADDR_REV_INT:   o_rdata <= {7'h00, rev_internal_torque_limit_reg};
                tls_pkg::ADDR_FWD_EXT:   o_rdata <= {7'h00, fwd_external_torque_limit_reg};
                tls_pkg::ADDR_REV_EXT:   o_rdata <= {7'h00, rev_external_torque_limit_reg};
                tls_pkg::ADDR_MODE:      o_rdata <= {12'h000, control_mode_select_reg};
                tls_pkg::ADDR_PAIR_A:    o_rdata <= {13'h0000, pair_sel_reg[0]};
                tls_pkg::ADDR_PAIR_B:    o_rdata <= {13'h0000, pair_sel_reg[1]};
                tls_pkg::ADDR_PAIR_C:    o_rdata <= {13'h0000, pair_sel_reg[2]};
                tls_pkg::ADDR_MOTOR_MAX: o_rdata <= {7'h00, motor_max_reg};
                tls_pkg::ADDR_STATUS:    o_rdata <= {11'h000, internal_speed, mode_sw_n,
                                                     rev_sel_n, fwd_sel_n, detect_n_reg};
                tls_pkg::ADDR_IRQ_STAT:  o_rdata <= {14'h0000, irq_stat_reg};
                tls_pkg::ADDR_IRQ_MASK:  o_rdata <= {14'h0000, irq_mask_reg};
                default:                 o_rdata <= 16'h0000;
            endcase
        end
        else
            o_rdata <= 16'h0000;
    end

    // =========================================================
    // Checks
    sequence s_over;
        over_fwd || over_rev;
    endsequence

    AST_DETECT_LOW: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        s_over |=> !o_torque_limit_detect_n) else $error("detect not low when over limit");
    AST_DETECT_HIGH: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !(over_fwd || over_rev) |=> o_torque_limit_detect_n) else $error("detect low under limit");
    AST_CLAMP: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        fwd_eff <= motor_max_reg && rev_eff <= motor_max_reg) else $error("limit above max");
    AST_FWD_SEL: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!internal_speed && !fwd_sel_n) |-> fwd_limit == fwd_external_torque_limit_reg)
        else $error("forward external not chosen");
    AST_REV_SEL: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!internal_speed && rev_sel_n) |-> rev_limit == rev_internal_torque_limit_reg)
        else $error("reverse internal not chosen");
    AST_MODE_IGNORE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        internal_speed |-> fwd_limit == fwd_internal_torque_limit_reg)
        else $error("select used in speed mode");
    AST_SPEED_DEC: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        internal_speed && !fwd_sel_n && rev_sel_n |=> o_speed_select == 2'b10)
        else $error("speed three not decoded");
    AST_PAIR_RANGE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        pair_sel_reg[0] <= tls_pkg::SEL_MAX) else $error("selector out of range");
    AST_ROUTE_CLT: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        pair_sel_reg[0] == 3'h3 && $stable(pair_sel_reg[0]) |=> o_pair_out[0] == $past(detect_n_reg))
        else $error("pair a not routing detect");
    AST_SYNC: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        ##2 fwd_sel_n == $past(i_fwd_limit_select_n, 2)) else $error("sync delay wrong");
    AST_LIM_RANGE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        fwd_internal_torque_limit_reg <= tls_pkg::PCT_MAX) else $error("limit above 300");

endmodule // tls_torque_limit

// ### bench/tls_host_model.sv
module tls_host_model
(
    // Clock
    input  wire logic                 i_clk,
    // Requests from the bench, active high
    input  wire logic [2:0]           i_req,
    input  wire logic [3:0]           i_src,
    // Contact pins, active low
    output logic                      o_fwd_limit_select_n,
    output logic                      o_rev_limit_select_n,
    output logic                      o_mode_switch_in_n,
    // Drive status sources
    output tls_pkg::tls_status_t      o_status
);
    timeunit 1ns;
    timeprecision 100ps;

    // =========================================================
    // Contacts idle open, so they power up inactive
    initial
    begin
        o_fwd_limit_select_n = 1'b1;
        o_rev_limit_select_n = 1'b1;
        o_mode_switch_in_n   = 1'b1;
        o_status             = 4'hf;
    end

    always @(posedge i_clk)
    begin
        o_fwd_limit_select_n <= ~i_req[0];
        o_rev_limit_select_n <= ~i_req[1];
        o_mode_switch_in_n   <= ~i_req[2];
        o_status             <= i_src;
    end
endmodule // tls_host_model

// ### bench/tls_torque_limit_tb_top.sv
module tls_torque_limit_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic                 i_clk = 1'b0;
    logic                 i_arst_n = 1'b0;
    logic [3:0]           i_addr = 4'h0;
    logic [15:0]          i_wdata = 16'h0000;
    logic                 i_wr = 1'b0;
    logic                 i_rd = 1'b0;
    logic signed [15:0]   i_torque_ref = 16'sh0000;
    logic [2:0]           req = 3'h0;
    logic [3:0]           src = 4'hf;
    logic [15:0]          o_rdata;
    logic signed [15:0]   o_torque_cmd;
    logic                 fwd_n;
    logic                 rev_n;
    logic                 sw_n;
    tls_pkg::tls_status_t status_w;
    logic                 o_det_n;
    logic [2:0]           o_pair_out;
    logic [1:0]           o_speed_select;
    logic                 o_speed_reverse;
    logic                 o_speed_mode_switch;
    logic                 o_irq;
    int                   regs[16];
    int                   num_errors = 0;
    int                   comparisons = 0;
    int                   cycles = 0;
    int                   prev_det = 1;
    int                   modes[9] = '{0, 1, 2, 3, 4, 5, 6, 7, 13};

    always #2.5 i_clk = ~i_clk;

    tls_torque_limit i_dut
    (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_fwd_limit_select_n(fwd_n), .i_rev_limit_select_n(rev_n),
        .i_mode_switch_in_n(sw_n), .i_torque_ref(i_torque_ref),
        .o_torque_cmd(o_torque_cmd), .i_status(status_w),
        .o_torque_limit_detect_n(o_det_n), .o_pair_out(o_pair_out),
        .o_speed_select(o_speed_select), .o_speed_reverse(o_speed_reverse),
        .o_speed_mode_switch(o_speed_mode_switch), .o_irq(o_irq)
    );

    tls_host_model i_host
    (
        .i_clk(i_clk), .i_req(req), .i_src(src), .o_fwd_limit_select_n(fwd_n),
        .o_rev_limit_select_n(rev_n), .o_mode_switch_in_n(sw_n), .o_status(status_w)
    );

    // =========================================================
    // Reporting
    task automatic close_out();
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Ceiling sits well above the roughly 6.6k cycles the sequence needs
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            num_errors++;
            close_out();
        end
    end

    // =========================================================
    // Reference model
    function automatic int lim(input bit fwd);
        bit spd = regs[4] inside {[3:6]};
        int l = fwd ? ((!spd && req[0]) ? regs[2] : regs[0])
                    : ((!spd && req[1]) ? regs[3] : regs[1]);
        return (l > regs[8]) ? regs[8] : l;
    endfunction

    function automatic int exp_reg(input int a);
        if (a == 9)
            return (regs[4] inside {[3:6]}) * 16 + !req[2] * 8 + !req[1] * 4 + !req[0] * 2
                   + prev_det;
        return regs[a];
    endfunction

    // =========================================================
    // Register bus
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        int v;
        v = int'(d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        case (a)
            0, 1, 2, 3, 8: regs[a] = (v > 300) ? 300 : v;
            4:             regs[a] = v & 15;
            5, 6, 7:       regs[a] = (v > 4) ? 4 : v;
            10:            regs[a] = regs[a] & ~v;
            11:            regs[a] = v & 3;
            default:       ;
        endcase
    endtask

    task automatic rd_check(input logic [3:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        check(o_rdata, 16'(exp_reg(int'(a))));
    endtask

    // =========================================================
    // Let contacts cross the synchroniser, then compare every output but o_rdata
    task automatic settle();
        int f, r, t, det, p, c, pair, spd;
        repeat (6) @(posedge i_clk);
        #1;
        f = lim(1);
        r = lim(0);
        t = int'(i_torque_ref);
        det = (t > f || t < -r) ? 0 : 1;
        if (det != prev_det)
            regs[10] = regs[10] | (det ? 2 : 1);
        prev_det = det;
        pair = 0;
        for (p = 0; p < 3; p++)
        begin
            c = regs[5 + p];
            pair += ((c == 3) ? det : src[(c == 4) ? 0 : 3 - c]) << p;
        end
        spd = regs[4] inside {[3:6]};
        check(o_torque_cmd, 16'((t > f) ? f : (t < -r) ? -r : t));
        check(16'(o_det_n), 16'(det));
        check(16'(o_pair_out), 16'(pair));
        check(16'({o_speed_select, o_speed_reverse, o_speed_mode_switch}),
              16'(spd ? req[0] * 8 + req[1] * 4 + req[2] * 2 + (req[1:0] == 0) : 0));
        check(16'(o_irq), 16'((regs[10] & regs[11]) != 0));
    endtask

    // =========================================================
    // Main sequence
    initial
    begin
        int i, k, f, r, t;
        regs = '{default: 0};
        regs[0] = 300;
        regs[1] = 300;
        regs[2] = 100;
        regs[3] = 100;
        regs[5] = 0;
        regs[6] = 1;
        regs[7] = 2;
        regs[8] = 300;
        void'($urandom(32'h24afe71a));
        repeat (8) @(posedge i_clk);
        i_arst_n <= 1'b1;
        for (k = 0; k < 16; k++) rd_check(4'(k));
        // Out of range limits and selectors saturate, mode keeps its low bits; read-only and unmapped writes vanish
        for (k = 0; k < 16; k++) wr_reg(4'(k), (k == 4) ? 16'hfff3 : 16'h0fff);
        for (k = 0; k < 12; k++) rd_check(4'(k));
        for (i = 0; i < 60; i++)
        begin
            for (k = 0; k < 4; k++)
            begin
                wr_reg(4'(k), 16'($urandom_range(300, 10)));
                settle();
            end
            wr_reg(4'h8, 16'($urandom_range(300, 50)));
            settle();
            wr_reg(4'h4, 16'(modes[i % 9]));
            settle();
            for (k = 5; k < 8; k++)
            begin
                wr_reg(4'(k), 16'((i + k) % 5));
                settle();
            end
            wr_reg(4'hb, 16'(i % 4));
            settle();
            @(posedge i_clk);
            req <= 3'($urandom_range(7));
            src <= 4'($urandom_range(15));
            settle();
            f = lim(1);
            r = lim(0);
            case (i % 5)
                0:       t = f;
                1:       t = f + 1;
                2:       t = -r;
                3:       t = -r - 1;
                default: t = int'($urandom_range(700)) - 350;
            endcase
            @(posedge i_clk);
            i_torque_ref <= 16'(t);
            settle();
            for (k = 9; k < 12; k++) rd_check(4'(k));
            wr_reg(4'ha, 16'($urandom_range(3)));
            settle();
        end
        close_out();
    end
endmodule // tls_torque_limit_tb_top
